//--- fsktx_params.svh
/*
 * Constants for the FSK transmitter command decoder: command codes,
 * reset values, field positions and bit-rate timing.
 * Assumes inclusion by bare name from the decoder.
 */
`ifndef FSKTX_PARAMS_SVH
`define FSKTX_PARAMS_SVH

// ************************************************************
// command codes (leading bits of each word)
// ************************************************************
`define FSKTX_CODE_CFG     4'h9
`define FSKTX_CODE_FREQ    4'hA
`define FSKTX_CODE_PWR     10'h300
`define FSKTX_CODE_FIFOSET 8'hCE
`define FSKTX_CODE_RATE    8'hC8
`define FSKTX_CODE_FWRITE  8'hC6

// ************************************************************
// reset values
// ************************************************************
`define FSKTX_RST_CFG      16'h9082
`define FSKTX_RST_FREQ     16'hAD57
`define FSKTX_RST_PWR      16'hC002
`define FSKTX_RST_FIFOSET  16'hCE00
`define FSKTX_RST_RATE     16'hC813

// ************************************************************
// channel word limits and field positions
// ************************************************************
`define FSKTX_CH_MIN       12'h060
`define FSKTX_CH_MAX       12'hF3F
`define FSKTX_PWR_XOSC     5
`define FSKTX_PWR_SYN      4
`define FSKTX_PWR_PA       3
`define FSKTX_PWR_LBD      2
`define FSKTX_PWR_WKT      1
`define FSKTX_PWR_CKO      0
`define FSKTX_FIFO_EN      7

// ************************************************************
// bit-rate timing: 10 MHz reference divided by 29
// ************************************************************
`define FSKTX_REF_HZ       10000000
`define FSKTX_SYS_HZ       125000000
`define FSKTX_RATE_PRE     29
// system cycles per base tick, truncated to 362; both clocks are scaled
// down first so that the product stays inside a 32-bit integer
`define FSKTX_PRE_CYC      ((`FSKTX_SYS_HZ / 1000) * `FSKTX_RATE_PRE / \
                            (`FSKTX_REF_HZ / 1000))

`endif

//--- fsktx_pkg.sv
/*
 * Types shared by the FSK transmitter command decoder.
 * Assumes fsktx_params.svh for numeric constants.
 */
package fsktx_pkg;

    // operating mode derived from the power enables
    typedef enum logic [1:0] {
        FSKTX_STANDBY,
        FSKTX_SLEEP,
        FSKTX_IDLE,
        FSKTX_ACTIVE
    } fsktx_mode_t;

    // decoded configuration fields
    typedef struct packed {
        logic       band_select;
        logic [2:0] pa_level;
        logic [3:0] xtal_load_trim;
        logic       dev_polarity;
        logic [2:0] deviation_step;
    } fsktx_cfg_t;

    // decoded power enables
    typedef struct packed {
        logic xtal_osc_on;
        logic synth_on;
        logic pa_on;
        logic lowbat_detect_on;
        logic wake_tmr_on;
        logic clkout_off;
    } fsktx_pwr_t;

    // bit-rate setting
    typedef struct packed {
        logic       prescale;
        logic [6:0] rate_divisor;
    } fsktx_rate_t;

endpackage

//--- fsktx_decoder.sv
/*
 * Serial command decoder and control registers of an FSK transmitter.
 * Serial port logic runs on the serial clock; the registers, transmit
 * buffer and bit-rate timer run on the system clock.
 *
 * Assumes the host keeps serial clock edges at least 25 ns apart, parks
 * the serial clock outside a frame, and holds each buffer data bit on
 * the port for at least four system cycles so that its toggle crosses
 * before the next one arrives.
 *
 * Limitations: the status read, wake-up timer, low-battery and clock
 * divider commands are not decoded and change nothing, as do unknown
 * codes and non-write words shorter than 16 bits. Buffer bits written while it
 * is full are dropped. The bit period is counted in whole system
 * cycles, so it runs a little fast (362 cycles for 362.5). Transmit
 * starts only on a rising amplifier enable; turning the buffer on while
 * the amplifier is already on does not start it.
 */
// Operation
// - host shifts bytes msb first, select low
// - reset loads default into every register
// - configuration command fields, default 9082h
// - band bit picks 868 or 915 MHz
// - power level: 3 dB steps down
// - crystal load trim: 0.5 pF steps
// - deviation sign is polarity xor modulation
// - frequency command holds 12-bit channel word
// - out-of-range channel word keeps old value
// - centre frequency from band and channel word
// - power command: six enables, default C002h
// - amplifier forces oscillator and synthesizer on
// - amplifier on with buffer starts buffer transmit
// - operating mode derived from the enables
// - buffer write command appends data bits
// - buffer command: enable, threshold, 64 deep
// - interrupt when remaining bits reach threshold
// - rate command: prescale, divisor, default C813h
`timescale 1ns/10ps
`include "fsktx_params.svh"

module fsktx_decoder
    import fsktx_pkg::*;
#(
    parameter int DEPTH = 64
) (
    // system clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    // serial command port
    input  wire logic        spi_clk_i,
    input  wire logic        port_select_n_i,
    input  wire logic        serial_in_i,
    // modulation input pin
    input  wire logic        fsk_mod_i,
    // decoded controls
    output fsktx_cfg_t       cfg_o,
    output logic [11:0]      channel_word_o,
    output fsktx_pwr_t       pwr_o,
    output logic             xosc_run_o,
    output logic             synth_run_o,
    output fsktx_mode_t      mode_o,
    output logic             fifo_on_o,
    output logic [5:0]       fifo_irq_level_o,
    output fsktx_rate_t      rate_o,
    // transmit data path
    output logic             tx_busy_o,
    output logic             mod_bit_o,
    output logic             dev_sign_o,
    output logic [6:0]       fifo_count_o,
    output logic             fifo_irq_o
);

    // ************************************************************
    // serial clock domain: shift register and word capture
    // ************************************************************

    logic [15:0] shreg_q;
    logic [4:0]  bitcnt_q;
    logic [15:0] word_q;
    logic        word_tgl_q;
    logic        dbit_q;
    logic        dbit_tgl_q;
    logic        wcode_seen;
    logic        fw_q;

    // select high clears the port asynchronously
    always_ff @(posedge spi_clk_i or posedge port_select_n_i) begin
        if (port_select_n_i) begin
            shreg_q  <= 16'h0000;
            bitcnt_q <= 5'h00;
        end else begin
            shreg_q <= {shreg_q[14:0], serial_in_i};
            if (bitcnt_q != 5'h1F) begin
                bitcnt_q <= bitcnt_q + 5'h01;
            end
        end
    end

    // word and data events cross as toggles; payload held stable
    // until the system clock has seen the toggle. a toggle survives
    // the stopped serial clock, where a one-cycle pulse would not
    always_ff @(posedge spi_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            word_q     <= 16'h0000;
            word_tgl_q <= 1'b0;
            dbit_q     <= 1'b0;
            dbit_tgl_q <= 1'b0;
        end else if (!port_select_n_i) begin
            if (bitcnt_q == 5'h0F) begin
                word_q     <= {shreg_q[14:0], serial_in_i};
                word_tgl_q <= ~word_tgl_q;
            end
            if (wcode_seen) begin
                dbit_q     <= serial_in_i;
                dbit_tgl_q <= ~dbit_tgl_q;
            end
        end
    end

    // after the 8-bit write code every further bit is buffer data;
    // the ninth bit decides from the shift register, later ones from
    // the latched match
    always_comb begin
        wcode_seen = (bitcnt_q >= 5'h08) &&
                     (bitcnt_q == 5'h08 ? shreg_q[7:0] == `FSKTX_CODE_FWRITE
                                        : fw_q);
    end

    // write code latch, cleared whenever select goes high
    always_ff @(posedge spi_clk_i or posedge port_select_n_i) begin
        if (port_select_n_i) begin
            fw_q <= 1'b0;
        end else if (bitcnt_q == 5'h08) begin
            fw_q <= (shreg_q[7:0] == `FSKTX_CODE_FWRITE);
        end
    end

    // ************************************************************
    // crossings into the system clock
    // ************************************************************

    logic [2:0] wsync_q;
    logic [2:0] dsync_q;
    logic [1:0] modsync_q;

    // two-flop synchronisers, third stage only for edge detection
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wsync_q   <= 3'h0;
            dsync_q   <= 3'h0;
            modsync_q <= 2'h0;
        end else begin
            wsync_q   <= {wsync_q[1:0], word_tgl_q};
            dsync_q   <= {dsync_q[1:0], dbit_tgl_q};
            modsync_q <= {modsync_q[0], fsk_mod_i};
        end
    end

    wire logic word_evt = wsync_q[2] ^ wsync_q[1];
    wire logic dbit_evt = dsync_q[2] ^ dsync_q[1];

    // ************************************************************
    // command registers
    // ************************************************************

    logic [15:0] cfg_q;
    logic [15:0] freq_q;
    logic [15:0] pwr_q;
    logic [15:0] fset_q;
    logic [15:0] rate_q;
    logic        pa_rise;

    logic        hit_cfg;
    logic        hit_freq;
    logic        hit_pwr;
    logic        hit_fset;
    logic        hit_rate;
    logic        chan_ok;

    // leading code bits of the captured word; the codes exclude one
    // another, so at most one register takes a full word
    assign hit_cfg  = word_evt && word_q[15:12] == `FSKTX_CODE_CFG;
    assign hit_freq = word_evt && word_q[15:12] == `FSKTX_CODE_FREQ;
    assign hit_pwr  = word_evt && word_q[15:6] == `FSKTX_CODE_PWR;
    assign hit_fset = word_evt && word_q[15:8] == `FSKTX_CODE_FIFOSET;
    assign hit_rate = word_evt && word_q[15:8] == `FSKTX_CODE_RATE;

    // a refused channel word leaves the stored one in place
    assign chan_ok = word_q[11:0] >= `FSKTX_CH_MIN &&
                     word_q[11:0] <= `FSKTX_CH_MAX;

    // configuration register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q <= `FSKTX_RST_CFG;
        end else if (hit_cfg) begin
            cfg_q <= word_q;
        end
    end

    // channel frequency register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            freq_q <= `FSKTX_RST_FREQ;
        end else if (hit_freq && chan_ok) begin
            freq_q <= word_q;
        end
    end

    // power enables register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwr_q <= `FSKTX_RST_PWR;
        end else if (hit_pwr) begin
            pwr_q <= word_q;
        end
    end

    // buffer setup register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fset_q <= `FSKTX_RST_FIFOSET;
        end else if (hit_fset) begin
            fset_q <= word_q;
        end
    end

    // bit-rate register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rate_q <= `FSKTX_RST_RATE;
        end else if (hit_rate) begin
            rate_q <= word_q;
        end
    end

    // band, power and trim codes go straight to the analogue side
    assign cfg_o          = cfg_q[11:0];
    assign channel_word_o = freq_q[11:0];
    assign pwr_o          = pwr_q[5:0];
    assign fifo_on_o      = fset_q[`FSKTX_FIFO_EN];
    assign fifo_irq_level_o = fset_q[5:0];
    assign rate_o         = rate_q[7:0];

    // amplifier drags oscillator and synthesizer along
    assign xosc_run_o  = pwr_q[`FSKTX_PWR_XOSC] | pwr_q[`FSKTX_PWR_PA];
    assign synth_run_o = pwr_q[`FSKTX_PWR_SYN] | pwr_q[`FSKTX_PWR_PA];

    // mode from enables; synthesizer alone counts as idle
    always_comb begin
        if (pwr_q[`FSKTX_PWR_PA]) begin
            mode_o = FSKTX_ACTIVE;
        end else if (pwr_q[`FSKTX_PWR_XOSC] | pwr_q[`FSKTX_PWR_SYN]) begin
            mode_o = FSKTX_IDLE;
        end else if (pwr_q[`FSKTX_PWR_LBD] | pwr_q[`FSKTX_PWR_WKT]) begin
            mode_o = FSKTX_SLEEP;
        end else begin
            mode_o = FSKTX_STANDBY;
        end
    end

    // ************************************************************
    // transmit buffer and bit-rate timer
    // ************************************************************

    logic [DEPTH-1:0] fifo_q;
    logic [6:0]       count_q;
    logic             pa_q;
    logic             tx_q;
    logic [8:0]       pre_q;
    logic [2:0]       ps_q;
    logic [6:0]       div_q;
    logic             tick;

    // prescaler: 29 reference periods per base tick
    // whole system cycles only; the lost half cycle per base tick
    // makes the rate about 0.14 percent fast
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_q <= 9'h000;
            ps_q  <= 3'h0;
            div_q <= 7'h00;
        end else if (!tx_q) begin
            pre_q <= 9'h000;
            ps_q  <= 3'h0;
            div_q <= 7'h00;
        end else if (pre_q == 9'(`FSKTX_PRE_CYC - 1)) begin
            pre_q <= 9'h000;
            if (ps_q == (rate_q[7] ? 3'h7 : 3'h0)) begin
                ps_q  <= 3'h0;
                div_q <= (div_q == rate_q[6:0]) ? 7'h00 : div_q + 7'h01;
            end else begin
                ps_q <= ps_q + 3'h1;
            end
        end else begin
            pre_q <= pre_q + 9'h001;
        end
    end

    // one bit period ends when all three counters sit at their tops
    assign tick = tx_q && pre_q == 9'(`FSKTX_PRE_CYC - 1) &&
                  ps_q == (rate_q[7] ? 3'h7 : 3'h0) &&
                  div_q == rate_q[6:0];

    // amplifier edge starts transmit while buffer enabled;
    // transmit stops at once when either enable drops
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pa_q <= 1'b0;
            tx_q <= 1'b0;
        end else begin
            pa_q <= pwr_q[`FSKTX_PWR_PA];
            if (!fifo_on_o || !pwr_q[`FSKTX_PWR_PA]) begin
                tx_q <= 1'b0;
            end else if (pa_rise) begin
                tx_q <= 1'b1;
            end
        end
    end
    assign pa_rise = pwr_q[`FSKTX_PWR_PA] & ~pa_q;

    // buffer: oldest bit at top; writes beyond depth are dropped
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fifo_q  <= '0;
            count_q <= 7'h00;
        end else if (!fifo_on_o) begin
            fifo_q  <= '0;
            count_q <= 7'h00;
        end else begin
            if (tick && count_q != 7'h00) begin
                // a bit arriving with the shift fills the slot just freed
                fifo_q <= {fifo_q[DEPTH-2:0], 1'b0};
                if (dbit_evt) begin
                    fifo_q[DEPTH-count_q] <= dbit_q;
                end else begin
                    count_q <= count_q - 7'h01;
                end
            end else if (dbit_evt && count_q < 7'(DEPTH)) begin
                fifo_q[DEPTH-1-count_q] <= dbit_q;
                count_q <= count_q + 7'h01;
            end
        end
    end

    // modulation source and deviation sign registers
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mod_bit_o  <= 1'b0;
            dev_sign_o <= 1'b0;
        end else begin
            mod_bit_o  <= tx_q ? fifo_q[DEPTH-1] : modsync_q[1];
            dev_sign_o <= cfg_q[3] ^
                          (tx_q ? fifo_q[DEPTH-1] : modsync_q[1]);
        end
    end

    // buffer interrupt: a level while the count sits at the threshold
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fifo_irq_o <= 1'b0;
        end else begin
            fifo_irq_o <= fifo_on_o &&
                          count_q == {1'b0, fset_q[5:0]};
        end
    end

    assign tx_busy_o    = tx_q;
    assign fifo_count_o = count_q;

endmodule // fsktx_decoder

//--- fsktx_checker.sv
/*
 * Port checker for the FSK transmitter command decoder.
 * Assumes binding onto fsktx_decoder, sampling on the system clock.
 */
`timescale 1ns/10ps

module fsktx_checker
    import fsktx_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    // decoded controls
    input fsktx_cfg_t       cfg_o,
    input wire logic [11:0] channel_word_o,
    input fsktx_pwr_t       pwr_o,
    input wire logic        xosc_run_o,
    input wire logic        synth_run_o,
    input fsktx_mode_t      mode_o,
    input wire logic        fifo_on_o,
    input wire logic [5:0]  fifo_irq_level_o,
    // transmit path
    input wire logic        tx_busy_o,
    input wire logic        mod_bit_o,
    input wire logic        dev_sign_o,
    input wire logic [6:0]  fifo_count_o,
    input wire logic        fifo_irq_o
);
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    chk_run_force: assert property (
        {xosc_run_o, synth_run_o} == {pwr_o.xtal_osc_on | pwr_o.pa_on,
                                      pwr_o.synth_on | pwr_o.pa_on})
        else $error("oscillator or synthesizer run wrong");
    chk_mode_active: assert property (
        pwr_o.pa_on |-> mode_o == FSKTX_ACTIVE)
        else $error("mode not active");
    chk_mode_idle: assert property (
        !pwr_o.pa_on && (pwr_o.xtal_osc_on || pwr_o.synth_on)
        |-> mode_o == FSKTX_IDLE) else $error("mode not idle");
    chk_mode_sleep: assert property (
        pwr_o[5:3] == 3'h0 && pwr_o[2:1] != 2'h0
        |-> mode_o == FSKTX_SLEEP) else $error("mode not sleep");
    chk_chan_range: assert property (
        channel_word_o inside {[12'h060:12'hF3F]})
        else $error("channel word out of range");
    chk_fifo_clear: assert property (
        (!fifo_on_o) [*3] |-> fifo_count_o == 7'h00)
        else $error("buffer not emptied");
    chk_irq_match: assert property (
        (fifo_on_o && fifo_count_o == {1'h0, fifo_irq_level_o}) [*2]
        |-> fifo_irq_o) else $error("buffer interrupt missing");
    chk_busy_stop: assert property (
        !(pwr_o.pa_on && fifo_on_o) |-> ##[0:2] !tx_busy_o)
        else $error("transmit did not stop");
    chk_dev_sign: assert property (
        $stable(cfg_o.dev_polarity) && $stable(mod_bit_o)
        |-> dev_sign_o == (cfg_o.dev_polarity ^ mod_bit_o))
        else $error("deviation sign wrong");

    // main scenarios reached
    cover property ($rose(tx_busy_o));
    cover property ($rose(fifo_irq_o));
    cover property (mode_o == FSKTX_IDLE);
endmodule // fsktx_checker

bind fsktx_decoder fsktx_checker u_chk (
    .clk_sys_i, .arst_n_i, .cfg_o, .channel_word_o, .pwr_o,
    .xosc_run_o, .synth_run_o, .mode_o, .fifo_on_o,
    .fifo_irq_level_o, .tx_busy_o, .mod_bit_o, .dev_sign_o,
    .fifo_count_o, .fifo_irq_o
);

//--- fsktx_host.sv
/*
 * Host model that drives the serial command port.
 * Assumes the decoder samples data on the rising serial clock.
 */
`timescale 1ns/10ps

module fsktx_host (
    // serial command port
    output logic spi_clk_o,
    output logic port_select_n_o,
    output logic serial_in_o
);
    // ************************************************************
    // word transfer
    // ************************************************************
    // idle: clock parked low, select high
    initial begin
        spi_clk_o       = 1'h0;
        port_select_n_o = 1'h1;
        serial_in_o     = 1'h0;
    end

    // top n bits of w, msb first; clock runs only inside the frame
    task automatic send(input logic [15:0] w, input int n);
        #5 port_select_n_o = 1'h0;
        for (int i = 15; i > 15 - n; i--) begin
            serial_in_o = w[i];
            #32 spi_clk_o = 1'h1;
            #32 spi_clk_o = 1'h0;
        end
        #10 port_select_n_o = 1'h1;
        // released line shows the inverse so a stale bit never passes
        serial_in_o = ~serial_in_o;
        #100; // select high long enough for the system clock
    endtask
endmodule // fsktx_host

//--- fsktx_tb.sv
/*
 * Self-checking bench for the command decoder, with a host model.
 * Assumes the package, the decoder and the bound checker are compiled.
 */
`timescale 1ns/10ps
`define CHK(act, exp) \
    begin \
        comparisons++; \
        if ((act) !== (exp)) begin \
            errors++; \
            $display("wrong value at %0t: %h not %h", $time, act, exp); \
        end \
    end

module tb;
    import fsktx_pkg::*;
    logic        clk_sys_i;
    logic        arst_n_i;
    logic        fsk_mod_i;
    wire logic   spi_clk;
    wire logic   sel_n;
    wire logic   serial_in;
    fsktx_cfg_t  cfg;
    logic [11:0] chan;
    fsktx_pwr_t  pwr;
    logic        xrun;
    logic        srun;
    fsktx_mode_t mode;
    logic        fon;
    logic [5:0]  lvl;
    fsktx_rate_t rate;
    logic        busy;
    logic        mbit;
    logic        dsign;
    logic [6:0]  cnt;
    logic        irq;
    int          errors;
    int          comparisons;

    // ************************************************************
    // instances and clock
    // ************************************************************
    fsktx_host host (.spi_clk_o(spi_clk), .port_select_n_o(sel_n),
                     .serial_in_o(serial_in));
    fsktx_decoder dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .spi_clk_i(spi_clk), .port_select_n_i(sel_n), .serial_in_i(serial_in),
        .fsk_mod_i(fsk_mod_i), .cfg_o(cfg), .channel_word_o(chan),
        .pwr_o(pwr), .xosc_run_o(xrun), .synth_run_o(srun), .mode_o(mode),
        .fifo_on_o(fon), .fifo_irq_level_o(lvl), .rate_o(rate),
        .tx_busy_o(busy), .mod_bit_o(mbit), .dev_sign_o(dsign),
        .fifo_count_o(cnt), .fifo_irq_o(irq));

    initial begin
        clk_sys_i = 1'h0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // one word, then time for the crossing to land
    task automatic cmd(input logic [15:0] w);
        host.send(w, 16);
        repeat (8) @(negedge clk_sys_i);
    endtask

    task automatic wrap_up;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_defaults;
        `CHK(cfg, 12'h082)
        `CHK(chan, 12'hD57)
        `CHK(pwr, 6'h02)
        `CHK(mode, FSKTX_SLEEP)
        `CHK({fon, lvl}, 7'h00)
        `CHK(rate, 8'h13)
    endtask

    // fields, then the modulation pin after settling
    task automatic t_cfg;
        cmd(16'h9F5B);
        `CHK(cfg, 12'hF5B)
        `CHK(cfg.band_select, 1'h1)
        `CHK(cfg.pa_level, 3'h7)
        `CHK(cfg.xtal_load_trim, 4'h5)
        cmd(16'hC038);
        fsk_mod_i = 1'h1;
        repeat (6) @(negedge clk_sys_i);
        `CHK(mbit, 1'h1)
        `CHK(dsign, 1'h0)
        fsk_mod_i = 1'h0;
        repeat (6) @(negedge clk_sys_i);
        `CHK(dsign, 1'h1)
    endtask

    // both range boundaries, each with a refused neighbour
    task automatic t_freq;
        logic [15:0] w [4] = '{16'hA060, 16'hA05F, 16'hAF3F, 16'hAF40};
        logic [11:0] e [4] = '{12'h060, 12'h060, 12'hF3F, 12'hF3F};
        for (int i = 0; i < 4; i++) begin
            cmd(w[i]);
            `CHK(chan, e[i])
        end
    endtask

    // foreign code and a short word change nothing
    task automatic t_refuse;
        cmd(16'hB0CA);
        host.send(16'hA123, 12);
        repeat (8) @(negedge clk_sys_i);
        `CHK(cfg, 12'hF5B)
        `CHK(chan, 12'hF3F)
    endtask

    task automatic t_power;
        logic [15:0] w [7] = '{16'hC008, 16'hC020, 16'hC010, 16'hC004,
                               16'hC002, 16'hC000, 16'hC001};
        fsktx_mode_t m [7] = '{FSKTX_ACTIVE, FSKTX_IDLE, FSKTX_IDLE,
            FSKTX_SLEEP, FSKTX_SLEEP, FSKTX_STANDBY, FSKTX_STANDBY};
        for (int i = 0; i < 7; i++) begin
            cmd(w[i]);
            `CHK(pwr, w[i][5:0])
            `CHK({xrun, srun}, {w[i][5] | w[i][3], w[i][4] | w[i][3]})
            `CHK(mode, m[i])
        end
    endtask

    // eight bits out at 362 cycles a bit, oldest first
    task automatic t_fifo;
        logic [7:0] d = 8'hA5;
        cmd(16'hC800);
        `CHK(rate, 8'h00)
        cmd(16'hCE84);
        `CHK({fon, lvl}, 7'h44)
        cmd(16'hC600 | d);
        `CHK(cnt, 7'h08)
        cmd(16'hC038);
        for (int i = 0; i < 50 && busy !== 1'h1; i++) @(negedge clk_sys_i);
        `CHK(busy, 1'h1)
        repeat (181) @(negedge clk_sys_i);
        for (int i = 7; i >= 0; i--) begin
            `CHK(mbit, d[i])
            `CHK(irq, 1'(i == 3))
            repeat (362) @(negedge clk_sys_i);
        end
        cmd(16'hCE00);
        `CHK({busy, cnt}, 8'h00)
        cmd(16'hC6FF);
        `CHK(cnt, 7'h00)
    endtask

    // prescaled rate with divisor 1: first bit holds 362 * 8 * 2 cycles
    task automatic t_prescale;
        cmd(16'hC881);
        `CHK(rate, 8'h81)
        cmd(16'hC000);
        cmd(16'hCE80);
        host.send(16'hC680, 10);
        repeat (8) @(negedge clk_sys_i);
        `CHK(cnt, 7'h02)
        cmd(16'hC038);
        repeat (5500) @(negedge clk_sys_i);
        `CHK(mbit, 1'h1)
        repeat (300) @(negedge clk_sys_i);
        `CHK(mbit, 1'h0)
    endtask

    // ************************************************************
    // sequence and watchdog
    // ************************************************************
    initial begin
        arst_n_i  = 1'h0;
        fsk_mod_i = 1'h0;
        repeat (16) @(negedge clk_sys_i);
        arst_n_i = 1'h1;
        repeat (4) @(negedge clk_sys_i);
        t_defaults();
        t_cfg();
        t_freq();
        t_refuse();
        t_power();
        t_fifo();
        t_prescale();
        wrap_up();
    end

    // the run takes near 12700 cycles; far beyond that means a hang
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        errors++;
        wrap_up();
    end
endmodule // tb
